// [verilog/gmd_pkg.sv]
`default_nettype none
package gmd_pkg;

    // ********************************************************
    // register map (byte addresses, one word each)
    // ********************************************************
    localparam logic [7:0] OFS_LIM_X   = 8'h00;
    localparam logic [7:0] OFS_LIM_Y   = 8'h04;
    localparam logic [7:0] OFS_LIM_Z   = 8'h08;
    localparam logic [7:0] OFS_MODAL_A = 8'h0C;
    localparam logic [7:0] OFS_MODAL_B = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h14;

    // rapid limit reset value, 10000.00 units/min in whole units
    localparam logic [15:0] LIM_RST = 16'h2710;

    // ********************************************************
    // preparatory codes and modal groups
    // ********************************************************
    localparam logic [6:0] G_RAPID = 7'h00;
    localparam logic [6:0] G_ZERO  = 7'h08;
    localparam logic [6:0] G_MAX   = 7'h63;
    localparam logic [6:0] G_NONE  = 7'h7F;

    localparam logic [3:0] GRP_MOTION  = 4'h0;
    localparam logic [3:0] GRP_PLANE   = 4'h1;
    localparam logic [3:0] GRP_UNITS   = 4'h2;
    localparam logic [3:0] GRP_RADCOMP = 4'h3;
    localparam logic [3:0] GRP_LENCOMP = 4'h4;
    localparam logic [3:0] GRP_WCS     = 4'h5;
    localparam logic [3:0] GRP_DRILL   = 4'h6;
    localparam logic [3:0] GRP_ABSINC  = 4'h7;
    localparam logic [3:0] GRP_RETLVL  = 4'h8;
    localparam logic [3:0] GRP_ONESHOT = 4'h9;
    localparam int         NGRP        = 9;

    // power-on codes, group 0 in the low bits: 98 90 80 54 49 40 21 17 01
    localparam logic [62:0] MODAL_RST = {7'h62, 7'h5A, 7'h50, 7'h36,
                                         7'h31, 7'h28, 7'h15, 7'h11, 7'h01};

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_PICK = 4'h2,
        ST_DIV  = 4'h4,
        ST_DONE = 4'h8
    } gmd_state_t;

    function automatic logic [3:0] gmd_group(input logic [6:0] c);
        if (c <= 7'h03)                      return GRP_MOTION;
        if (c >= 7'h11 && c <= 7'h13)        return GRP_PLANE;
        if (c == 7'h14 || c == 7'h15)        return GRP_UNITS;
        if (c >= 7'h28 && c <= 7'h2A)        return GRP_RADCOMP;
        if (c == 7'h2B || c == 7'h2C || c == 7'h31) return GRP_LENCOMP;
        if (c >= 7'h36 && c <= 7'h3B)        return GRP_WCS;
        if (c >= 7'h50 && c <= 7'h59)        return GRP_DRILL;
        if (c == 7'h5A || c == 7'h5B)        return GRP_ABSINC;
        if (c == 7'h62 || c == 7'h63)        return GRP_RETLVL;
        return GRP_ONESHOT;
    endfunction

endpackage
`default_nettype wire

// [verilog/gmd_decoder.sv]
// Notes on behaviour
// - codes 0..99 accepted as numeric values; 4 and 04 are the same code
// - one-shot code holds for its own block only, dropped at next block
// - modal code stays until another code of its group arrives
// - nine modal groups: motion, plane, units, radius, length, wcs, ...
// - several codes in one block: only the last one counts
// - power-on: linear cutting, radius comp cancelled, first work system
// - code 08 clears machine coordinates; 90/91 select abs/incremental
// - 41 left, 42 right radius compensation, 40 cancels
// - 54..59 select work coordinate systems one to six, modally
// - 20/21 select inch or metric units, modally
// - 17/18/19 select plane X-Y, Z-X, Y-Z, modally
// - rapid: X/Y/Z absolute targets, U/V/W increments, one to three axes
// - rapid starts from end of previous block; displacements are signed
// - each axis's rapid speed bounded by its own limit register
// - longest axis gets base speed, others scaled by distance ratio
// - over-limit axis clamps to its limit, others rescaled from it
`timescale 1ns/1ps
`default_nettype none
module gmd_decoder #(
    parameter int PW = 24,
    parameter int LW = 16
) (
    input  wire logic            clk_sys_i,
    input  wire logic            srst_i,
    // block parser side
    input  wire logic            gcode_valid_i,
    input  wire logic [6:0]      gcode_num_i,
    input  wire logic            blk_end_i,
    input  wire logic [2:0]      abs_has_i,
    input  wire logic [3*PW-1:0] abs_pos_i,
    input  wire logic [2:0]      inc_has_i,
    input  wire logic [3*PW-1:0] inc_pos_i,
    output logic                 blk_ready_o,
    // motion generator side
    output logic [62:0]          modal_o,
    output logic [6:0]           oneshot_o,
    output logic                 coord_clr_o,
    output logic [3*PW-1:0]      pos_o,
    output logic                 rapid_valid_o,
    output logic [3*LW-1:0]      rapid_spd_o,
    // AHB-Lite slave
    input  wire logic            hsel_i,
    input  wire logic [31:0]     haddr_i,
    input  wire logic [1:0]      htrans_i,
    input  wire logic            hwrite_i,
    input  wire logic [2:0]      hsize_i,
    input  wire logic            hready_i,
    input  wire logic [31:0]     hwdata_i,
    output logic [31:0]          hrdata_o,
    output logic                 hreadyout_o,
    output logic                 hresp_o
);

    localparam int DW = PW + LW;
    localparam int CW = $clog2(DW + 1);

    generate
        if (LW < 8 || LW > 31 || PW < 4 || DW > 62) begin : g_bad
            $error("gmd_decoder: unsupported PW/LW");
        end
    endgenerate

    // ********************************************************
    // code collection and modal state
    // ********************************************************
    gmd_pkg::gmd_state_t state_r;
    gmd_pkg::gmd_state_t state_nxt;

    logic [6:0]  pend_r;
    logic        pend_vld_r;
    logic [62:0] modal_r;
    logic [6:0]  oneshot_r;
    logic        clr_r;
    logic        ready_r;

    wire        idle      = (state_r == gmd_pkg::ST_IDLE);
    wire        code_ok   = gcode_valid_i && (gcode_num_i <= gmd_pkg::G_MAX);
    wire        blk_acc   = blk_end_i && idle;
    wire [6:0]  eff_code  = code_ok ? gcode_num_i : pend_r;
    wire        eff_vld   = code_ok || pend_vld_r;
    wire [3:0]  eff_grp   = gmd_pkg::gmd_group(eff_code);
    wire        zero_hit  = blk_acc && eff_vld && eff_code == gmd_pkg::G_ZERO;
    wire [6:0]  motion_ef = (eff_vld && eff_grp == gmd_pkg::GRP_MOTION) ?
                            eff_code : modal_r[6:0];

    // a later code simply overwrites the pending one
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            pend_r     <= gmd_pkg::G_NONE;
            pend_vld_r <= 1'b0;
        end else if (blk_acc) begin
            pend_vld_r <= 1'b0;
        end else if (code_ok && idle) begin
            pend_r     <= gcode_num_i;
            pend_vld_r <= 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < gmd_pkg::NGRP; g++) begin : g_grp
            wire hit = blk_acc && eff_vld && eff_grp == 4'(g);
            always_ff @(posedge clk_sys_i) begin
                if (srst_i) begin
                    modal_r[g*7 +: 7] <= gmd_pkg::MODAL_RST[g*7 +: 7];
                end else if (hit) begin
                    modal_r[g*7 +: 7] <= eff_code;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            oneshot_r <= gmd_pkg::G_NONE;
            clr_r     <= 1'b0;
        end else begin
            clr_r <= zero_hit;
            if (blk_acc) begin
                oneshot_r <= (eff_vld && eff_grp == gmd_pkg::GRP_ONESHOT) ?
                             eff_code : gmd_pkg::G_NONE;
            end
        end
    end

    // ********************************************************
    // positions and distances
    // ********************************************************
    logic signed [PW-1:0] pos_r [0:2];
    logic        [PW-1:0] mag_r [0:2];
    logic        [PW-1:0] mag_w [0:2];
    logic        [LW-1:0] lim_r [0:2];
    logic        [LW-1:0] spd_r [0:2];

    genvar a;
    generate
        for (a = 0; a < 3; a++) begin : g_ax
            wire signed [PW-1:0] cur = pos_r[a];
            wire signed [PW-1:0] ab  = abs_pos_i[a*PW +: PW];
            wire signed [PW-1:0] in  = inc_pos_i[a*PW +: PW];
            // the increment wins when both forms name the same axis
            wire signed [PW-1:0] tgt = inc_has_i[a] ? PW'(cur + in) :
                                       abs_has_i[a] ? ab : cur;
            wire signed [PW-1:0] dlt = PW'(tgt - cur);
            assign mag_w[a] = dlt[PW-1] ? PW'(-dlt) : dlt;
            always_ff @(posedge clk_sys_i) begin
                if (srst_i) begin
                    pos_r[a] <= '0;
                    mag_r[a] <= '0;
                end else if (zero_hit) begin
                    pos_r[a] <= '0;
                    mag_r[a] <= '0;
                end else if (blk_acc) begin
                    pos_r[a] <= tgt;
                    mag_r[a] <= mag_w[a];
                end
            end
            assign pos_o[a*PW +: PW]       = pos_r[a];
            assign rapid_spd_o[a*LW +: LW] = spd_r[a];
        end
    endgenerate

    wire go_rapid = blk_acc && !zero_hit && motion_ef == gmd_pkg::G_RAPID &&
                    (|{mag_w[0], mag_w[1], mag_w[2]});

    // ********************************************************
    // rapid speed scaler
    // ********************************************************
    // axis a binds tighter than b when lim_a/m_a < lim_b/m_b; the binding
    // axis runs at its own limit, which is the longest-axis base speed
    // clamped by any other axis that would overrun
    function automatic logic tighter(input logic [LW-1:0] la,
                                     input logic [PW-1:0] ma,
                                     input logic [LW-1:0] lb,
                                     input logic [PW-1:0] mb);
        logic [DW-1:0] pa;
        logic [DW-1:0] pb;
        pa = DW'(la) * DW'(mb);
        pb = DW'(lb) * DW'(ma);
        return (ma != '0) && ((mb == '0) || pa < pb);
    endfunction

    wire       t01 = tighter(lim_r[0], mag_r[0], lim_r[1], mag_r[1]);
    wire [1:0] k01 = t01 ? 2'd0 : 2'd1;
    wire [1:0] kb  = tighter(lim_r[k01], mag_r[k01], lim_r[2], mag_r[2]) ?
                     k01 : 2'd2;

    logic [LW-1:0] num_r;
    logic [PW-1:0] den_r;
    logic [DW-1:0] dvd_r;
    logic [DW-1:0] quo_r;
    logic [PW:0]   rem_r;
    logic [CW-1:0] cnt_r;
    logic [1:0]    idx_r;
    logic          rv_r;

    // restoring divider step: one quotient bit per cycle
    wire [PW:0]    trial  = {rem_r[PW-1:0], dvd_r[DW-1]};
    wire           fits   = trial >= {1'b0, den_r};
    wire [PW:0]    rem_nx = fits ? (PW+1)'(trial - {1'b0, den_r}) : trial;
    wire [DW-1:0]  quo_nx = {quo_r[DW-2:0], fits};
    wire           last   = (cnt_r == CW'(1));
    wire [1:0]     idx_nx = idx_r + 2'd1;

    function automatic logic [DW-1:0] load(input logic [PW-1:0] m,
                                           input logic [LW-1:0] n);
        return DW'(m) * DW'(n);
    endfunction

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            gmd_pkg::ST_IDLE: begin
                if (go_rapid) begin
                    state_nxt = gmd_pkg::ST_PICK;
                end
            end
            gmd_pkg::ST_PICK: state_nxt = gmd_pkg::ST_DIV;
            gmd_pkg::ST_DIV: begin
                if (last && idx_r == 2'd2) begin
                    state_nxt = gmd_pkg::ST_DONE;
                end
            end
            gmd_pkg::ST_DONE: state_nxt = gmd_pkg::ST_IDLE;
            default:          state_nxt = gmd_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_r <= gmd_pkg::ST_IDLE;
            ready_r <= 1'b0;
            rv_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ready_r <= (state_nxt == gmd_pkg::ST_IDLE);
            rv_r    <= (state_r == gmd_pkg::ST_DONE);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            num_r <= '0;
            den_r <= '0;
            dvd_r <= '0;
            quo_r <= '0;
            rem_r <= '0;
            cnt_r <= '0;
            idx_r <= 2'd0;
            for (int i = 0; i < 3; i++) begin
                spd_r[i] <= '0;
            end
        end else if (state_r == gmd_pkg::ST_PICK) begin
            num_r <= lim_r[kb];
            den_r <= mag_r[kb];
            dvd_r <= load(mag_r[0], lim_r[kb]);
            quo_r <= '0;
            rem_r <= '0;
            cnt_r <= CW'(DW);
            idx_r <= 2'd0;
        end else if (state_r == gmd_pkg::ST_DIV) begin
            if (last) begin
                // speed = m_i * lim_k / m_k, never above lim_i
                spd_r[idx_r] <= LW'(quo_nx);
                idx_r        <= idx_nx;
                dvd_r        <= load(mag_r[idx_nx], num_r);
                quo_r        <= '0;
                rem_r        <= '0;
                cnt_r        <= CW'(DW);
            end else begin
                dvd_r <= {dvd_r[DW-2:0], 1'b0};
                quo_r <= quo_nx;
                rem_r <= rem_nx;
                cnt_r <= cnt_r - CW'(1);
            end
        end
    end

    assign blk_ready_o   = ready_r;
    assign modal_o       = modal_r;
    assign oneshot_o     = oneshot_r;
    assign coord_clr_o   = clr_r;
    assign rapid_valid_o = rv_r;

    // ********************************************************
    // AHB-Lite register slave
    // ********************************************************
    // reads take one wait state so a write just before is always seen
    logic        wr_r;
    logic        rd_r;
    logic [7:0]  adr_r;
    logic [31:0] hrdata_r;
    logic        hready_r;

    wire        bus_acc = hsel_i && htrans_i[1] && hready_i;
    wire [31:0] rd_mux  =
        (adr_r == gmd_pkg::OFS_LIM_X)   ? 32'(lim_r[0]) :
        (adr_r == gmd_pkg::OFS_LIM_Y)   ? 32'(lim_r[1]) :
        (adr_r == gmd_pkg::OFS_LIM_Z)   ? 32'(lim_r[2]) :
        (adr_r == gmd_pkg::OFS_MODAL_A) ? {4'h0, modal_r[27:0]} :
        (adr_r == gmd_pkg::OFS_MODAL_B) ? {4'h0, modal_r[55:28]} :
        (adr_r == gmd_pkg::OFS_STATUS)  ?
            {17'h00000, ~ready_r, oneshot_r, modal_r[62:56]} : 32'h00000000;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            wr_r     <= 1'b0;
            rd_r     <= 1'b0;
            adr_r    <= 8'h00;
            hrdata_r <= 32'h00000000;
            hready_r <= 1'b1;
        end else begin
            wr_r <= bus_acc && hwrite_i;
            rd_r <= bus_acc && !hwrite_i;
            if (bus_acc) begin
                adr_r <= haddr_i[7:0];
            end
            if (bus_acc && !hwrite_i) begin
                hready_r <= 1'b0;
            end else if (rd_r) begin
                hready_r <= 1'b1;
                hrdata_r <= rd_mux;
            end
        end
    end

    generate
        for (a = 0; a < 3; a++) begin : g_lim
            wire [7:0] ofs = (a == 0) ? gmd_pkg::OFS_LIM_X :
                             (a == 1) ? gmd_pkg::OFS_LIM_Y :
                                        gmd_pkg::OFS_LIM_Z;
            always_ff @(posedge clk_sys_i) begin
                if (srst_i) begin
                    lim_r[a] <= LW'(gmd_pkg::LIM_RST);
                end else if (wr_r && adr_r == ofs) begin
                    lim_r[a] <= hwdata_i[LW-1:0];
                end
            end
        end
    endgenerate

    assign hrdata_o    = hrdata_r;
    assign hreadyout_o = hready_r;
    assign hresp_o     = 1'b0;

    // ********************************************************
    // assertions
    // ********************************************************
    oneshot_drop_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        blk_acc && !(eff_vld && eff_grp == gmd_pkg::GRP_ONESHOT)
        |=> oneshot_o == gmd_pkg::G_NONE)
        else $error("one-shot code outlived its block");
    modal_hold_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        blk_acc && !eff_vld |=> $stable(modal_o))
        else $error("modal state changed without a code");
    power_on_a: assert property (@(posedge clk_sys_i)
        $fell(srst_i) |-> modal_o[6:0] == 7'h01 && modal_o[27:21] == 7'h28
        && modal_o[41:35] == 7'h36)
        else $error("wrong power-on modal state");
    last_code_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        code_ok && idle && !blk_end_i ##1 blk_end_i && idle && !gcode_valid_i
        && gmd_pkg::gmd_group($past(gcode_num_i)) == gmd_pkg::GRP_MOTION
        |=> modal_o[6:0] == $past(gcode_num_i, 2))
        else $error("last code in block not applied");
    zero_clear_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        zero_hit |=> coord_clr_o && pos_o == '0 ##1 !coord_clr_o)
        else $error("coordinate clear misbehaved");
    radius_sel_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        blk_acc && eff_vld && eff_code == 7'h29 |=> modal_o[27:21] == 7'h29)
        else $error("left radius compensation not held");
    speed_cap_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        rapid_valid_o |-> spd_r[0] <= lim_r[0] && spd_r[1] <= lim_r[1]
        && spd_r[2] <= lim_r[2])
        else $error("rapid speed above axis limit");
    base_axis_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        rapid_valid_o |-> (spd_r[0] == lim_r[0] && mag_r[0] != '0)
        || (spd_r[1] == lim_r[1] && mag_r[1] != '0)
        || (spd_r[2] == lim_r[2] && mag_r[2] != '0))
        else $error("no axis runs at its limit");
    rapid_done_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        go_rapid |=> !blk_ready_o [*1] ##[1:200] rapid_valid_o)
        else $error("rapid scaling did not finish");

endmodule // gmd_decoder
`default_nettype wire

// [dv/gmd_parser_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// block parser: hands codes and position words to the decoder
// ************************************************************
module gmd_parser_model #(
    parameter int PW = 24
) (
    input  wire logic            clk_sys_i,
    input  wire logic            blk_ready_i,
    output logic                 gcode_valid_o,
    output logic [6:0]           gcode_num_o,
    output logic                 blk_end_o,
    output logic [2:0]           abs_has_o,
    output logic [3*PW-1:0]      abs_pos_o,
    output logic [2:0]           inc_has_o,
    output logic [3*PW-1:0]      inc_pos_o
);
    initial begin
        gcode_valid_o = 1'b0;
        gcode_num_o   = 7'h00;
        blk_end_o     = 1'b0;
        abs_has_o     = 3'h0;
        abs_pos_o     = '0;
        inc_has_o     = 3'h0;
        inc_pos_o     = '0;
    end

    // 7F means no code; the second code rides with the block end
    task automatic send_blk(input logic [6:0] ca, input logic [6:0] cb,
                            input logic [2:0] ah, input logic [3*PW-1:0] ap,
                            input logic [2:0] ih, input logic [3*PW-1:0] ip);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (blk_ready_i !== 1'b1 && n < 400);
        if (ca != 7'h7F) begin
            gcode_valid_o <= 1'b1;
            gcode_num_o   <= ca;
            @(posedge clk_sys_i);
        end
        gcode_valid_o <= (cb != 7'h7F);
        gcode_num_o   <= cb;
        blk_end_o     <= 1'b1;
        abs_has_o     <= ah;
        abs_pos_o     <= ap;
        inc_has_o     <= ih;
        inc_pos_o     <= ip;
        @(posedge clk_sys_i);
        // released words must not look like the last block's data
        gcode_valid_o <= 1'b0;
        gcode_num_o   <= ~cb;
        blk_end_o     <= 1'b0;
        abs_has_o     <= ~ah;
        abs_pos_o     <= ~ap;
        inc_has_o     <= ~ih;
        inc_pos_o     <= ~ip;
    endtask
endmodule // gmd_parser_model
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int PW = 24;
    localparam int LW = 16;
    logic            clk_sys_i;
    logic            srst_i;
    logic            gv;
    logic            be;
    logic [6:0]      gn;
    logic [2:0]      ah;
    logic [2:0]      ih;
    logic [3*PW-1:0] ap;
    logic [3*PW-1:0] ip;
    logic [3*PW-1:0] pos_o;
    logic            blk_ready_o;
    logic            coord_clr_o;
    logic            rapid_valid_o;
    logic [62:0]     modal_o;
    logic [62:0]     em;
    logic [6:0]      oneshot_o;
    logic [3*LW-1:0] rapid_spd_o;
    logic            hsel_i;
    logic            hwrite_i;
    logic            hreadyout_o;
    logic            hresp_o;
    logic [31:0]     haddr_i;
    logic [31:0]     hwdata_i;
    logic [31:0]     hrdata_o;
    logic [31:0]     rd;
    logic [1:0]      htrans_i;
    logic [2:0]      hsize_i;
    int              err_total;
    int              cmp_count;
    int              clr_cnt;

    // ********************************************************
    // clock, design and parser
    // ********************************************************
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    gmd_decoder #(.PW(PW), .LW(LW)) dut (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .gcode_valid_i(gv),
        .gcode_num_i(gn), .blk_end_i(be), .abs_has_i(ah), .abs_pos_i(ap),
        .inc_has_i(ih), .inc_pos_i(ip), .blk_ready_o(blk_ready_o),
        .modal_o(modal_o), .oneshot_o(oneshot_o), .coord_clr_o(coord_clr_o),
        .pos_o(pos_o), .rapid_valid_o(rapid_valid_o),
        .rapid_spd_o(rapid_spd_o), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hready_i(hreadyout_o), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o));

    gmd_parser_model #(.PW(PW)) u_prs (
        .clk_sys_i(clk_sys_i), .blk_ready_i(blk_ready_o),
        .gcode_valid_o(gv), .gcode_num_o(gn), .blk_end_o(be),
        .abs_has_o(ah), .abs_pos_o(ap), .inc_has_o(ih), .inc_pos_o(ip));

    always @(posedge clk_sys_i) begin
        if (coord_clr_o === 1'b1) begin
            clr_cnt <= clr_cnt + 1;
        end
    end

    // ********************************************************
    // shared tasks
    // ********************************************************
    task automatic chk(input string nm, input logic [71:0] e,
                       input logic [71:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic settle;
        @(posedge clk_sys_i);
        #1;
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        hsel_i   <= 1'b1;
        htrans_i <= 2'b10;
        haddr_i  <= a;
        hwrite_i <= wr;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (hreadyout_o !== 1'b1 && n < 50);
        hsel_i   <= 1'b0;
        htrans_i <= 2'b00;
        hwdata_i <= wd;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (hreadyout_o !== 1'b1 && n < 100);
        q = hrdata_o;
    endtask

    task automatic wait_rapid(input logic [47:0] e);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (rapid_valid_o !== 1'b1 && n < 400);
        #1;
        chk("rapid_spd_o", {24'h0, e}, {24'h0, rapid_spd_o});
    endtask

    task automatic chk_modal(input logic [6:0] os);
        chk("modal_o", {9'h0, em}, {9'h0, modal_o});
        chk("oneshot_o", {65'h0, os}, {65'h0, oneshot_o});
    endtask

    // ********************************************************
    // scenarios
    // ********************************************************
    task automatic t_reset;
        chk_modal(7'h7F);
        chk("pos_o", 72'h0, pos_o);
        chk("hresp_o", 72'h0, {71'h0, hresp_o});
        for (int i = 0; i < 3; i++) begin
            ahb(1'b0, 32'(4 * i), 32'h0, rd);
            chk("lim", 72'h2710, {40'h0, rd});
        end
        ahb(1'b0, 32'h0000_0018, 32'h0, rd);
        chk("unmapped", 72'h0, {40'h0, rd});
    endtask

    task automatic t_rapid;
        u_prs.send_blk(7'h7F, gmd_pkg::G_RAPID, 3'b111,
                       {24'h000014, 24'h000032, 24'h000064}, 3'b000, 72'h0);
        settle();
        chk("blk_ready_o", 72'h0, {71'h0, blk_ready_o});
        chk("pos_o", {24'h000014, 24'h000032, 24'h000064}, pos_o);
        wait_rapid({16'h07D0, 16'h1388, 16'h2710});
        ahb(1'b1, 32'h0, 32'h0000_0BB8, rd);
        ahb(1'b1, 32'h4, 32'h0000_03E8, rd);
        ahb(1'b0, 32'h4, 32'h0, rd);
        chk("lim_y", 72'h3E8, {40'h0, rd});
        // no code: rapid stays; increment beats the absolute word
        u_prs.send_blk(7'h7F, 7'h7F, 3'b001, {48'h0, 24'h0003E7},
                       3'b011, {24'h0, 24'h000032, 24'hFFFF9C});
        settle();
        chk("pos_o", {24'h000014, 24'h000064, 24'h000000}, pos_o);
        wait_rapid({16'h0000, 16'h03E8, 16'h07D0});
        chk_modal(7'h7F);
    endtask

    task automatic t_modal;
        byte cl [23] = '{8'h02, 8'h03, 8'h01, 8'h12, 8'h13, 8'h11, 8'h14,
                         8'h15, 8'h29, 8'h2A, 8'h28, 8'h2B, 8'h2C, 8'h31,
                         8'h37, 8'h3B, 8'h36, 8'h59, 8'h50, 8'h5B, 8'h5A,
                         8'h63, 8'h62};
        byte gl [23] = '{0, 0, 0, 1, 1, 1, 2, 2, 3, 3, 3, 4, 4, 4, 5, 5, 5,
                         6, 6, 7, 7, 8, 8};
        for (int i = 0; i < 23; i++) begin
            u_prs.send_blk(7'h7F, cl[i][6:0], 3'b000, 72'h0, 3'b000, 72'h0);
            settle();
            em[int'(gl[i])*7+:7] = cl[i][6:0];
            chk_modal(7'h7F);
        end
    endtask

    task automatic t_last;
        u_prs.send_blk(7'h02, 7'h29, 3'b000, 72'h0, 3'b000, 72'h0);
        settle();
        em[27:21] = 7'h29;
        chk_modal(7'h7F);
        u_prs.send_blk(7'h2A, 7'h28, 3'b000, 72'h0, 3'b000, 72'h0);
        settle();
        em[27:21] = 7'h28;
        chk_modal(7'h7F);
        // lone code ahead of a bare block end still applies
        u_prs.send_blk(7'h03, 7'h7F, 3'b000, 72'h0, 3'b000, 72'h0);
        settle();
        em[6:0] = 7'h03;
        chk_modal(7'h7F);
    endtask

    task automatic t_oneshot;
        u_prs.send_blk(7'h7F, 7'h04, 3'b000, 72'h0, 3'b000, 72'h0);
        settle();
        chk_modal(7'h04);
        // out of range code leaves the block empty
        u_prs.send_blk(7'h7F, 7'h64, 3'b000, 72'h0, 3'b000, 72'h0);
        settle();
        chk_modal(7'h7F);
        u_prs.send_blk(7'h7F, gmd_pkg::G_ZERO, 3'b111, {3{24'h000100}},
                       3'b000, 72'h0);
        settle();
        settle();
        chk("pos_o", 72'h0, pos_o);
        chk("coord_clr", 72'h1, {40'h0, 32'(clr_cnt)});
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk_sys_i);
        err_total++;
        test_done();
    end

    initial begin
        srst_i    = 1'b1;
        hsel_i    = 1'b0;
        haddr_i   = 32'h0;
        htrans_i  = 2'b00;
        hwrite_i  = 1'b0;
        hsize_i   = 3'b010;
        hwdata_i  = 32'h0;
        err_total = 0;
        cmp_count = 0;
        clr_cnt   = 0;
        em        = gmd_pkg::MODAL_RST;
        repeat (12) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        settle();
        t_reset();
        em[6:0] = gmd_pkg::G_RAPID;
        t_rapid();
        t_modal();
        t_last();
        t_oneshot();
        test_done();
    end
endmodule // tb_top
`default_nettype wire
